/* File: verification/spa_remote_node.sv */
/* Remote node: sends 11-bit frames on rxd, samples txd mid-bit.
   Assumes bit period in ref_clk cycles. */
`timescale 1ns/1ns
`default_nettype none
module spa_remote_node (
    input wire logic ref_clk,
    input wire logic txd,
    output var logic rxd
);
    logic [15:0] got;
    // ====================
    // Pulled-up line idles high
    initial rxd = 1'b1;
    task automatic send(input logic [10:0] bits, input int p);
        for (int i = 0; i < 11; i++) begin
            rxd <= bits[i];
            repeat (p) @(posedge ref_clk);
        end
        rxd <= 1'b1;
    endtask
    // Idle ones fill short frames
    task automatic listen(input int p);
        int k;
        got = 16'h0000;
        for (k = 0; txd !== 1'b0 && k < 400; k++) @(negedge ref_clk);
        repeat (p / 2) @(negedge ref_clk);
        for (int i = 0; i < 11; i++) begin
            got[i] = txd;
            repeat (p) @(negedge ref_clk);
        end
    endtask
endmodule // spa_remote_node
`default_nettype wire

/* File: verification/spa_serial_port_bench.sv */
/* Bench for spa_serial_port: registers, frames, address match, switchback.
   Assumes the remote node model and the bound checker are compiled. */
`timescale 1ns/1ns
`default_nettype none
module spa_serial_port_bench;
    logic ref_clk, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic p0TxStart = 1'b0, p0RxStart = 1'b0, p0TiSet = 1'b0, p0RiSet = 1'b0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic [7:0] p0RxAddr = 8'h00;
    wire logic hready, txd, rxd, rxdOe, p0AddrMatch;
    wire logic [31:0] hrdata;
    wire logic [1:0] clkDivSel;
    logic [15:0] rdv;
    int failures, cmp_count, k;
    spa_serial_port u_dut (.ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hrdata(hrdata),
        .hresp(), .txd(txd), .rxdIn(rxd), .rxdOut(), .rxdOe(rxdOe), .p0TxStart(p0TxStart),
        .p0RxStart(p0RxStart), .p0TiSet(p0TiSet), .p0RiSet(p0RiSet), .p0RxAddr(p0RxAddr),
        .p0AddrMatch(p0AddrMatch), .clkDivSel(clkDivSel));
    spa_remote_node u_node (.ref_clk(ref_clk), .txd(txd), .rxd(rxd));
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // ====================
    // Shared tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) failures++;
        if (got !== exp) $display("[ERR] %0t got %h exp %h", $time, got, exp);
    endtask
    task automatic close_out();
        if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic wt();
        int n;
        @(negedge ref_clk);
        for (n = 0; hready !== 1'b1 && n < 50; n++) @(negedge ref_clk);
        if (n == 50) failures++;
        if (n == 50) close_out();
        rdv = {8'h00, hrdata[7:0]};
        @(posedge ref_clk);
    endtask
    task automatic bus(input logic w, input logic [7:0] ix, input logic [7:0] wd);
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {22'h0, ix, 2'h0};
        wt();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        wt();
    endtask
    task automatic wr(input logic [7:0] ix, input logic [7:0] wd);
        bus(1'b1, ix, wd);
    endtask
    task automatic rc(input logic [7:0] ix, input logic [15:0] exp);
        bus(1'b0, ix, 8'h00);
        chk(rdv, exp);
    endtask
    // ====================
    // Scenarios
    task automatic m0(input logic [7:0] a, input logic e);
        p0RxAddr <= a;
        @(negedge ref_clk);
        chk({15'h0, p0AddrMatch}, {15'h0, e});
    endtask
    // Divide write mid-frame must bounce while receive activity is set, else it takes effect
    task automatic rxf(input logic [8:0] d9, input int p, input logic [7:0] ctl, input logic [7:0] bv,
        input logic act);
        fork
            u_node.send({1'b1, d9, 1'b0}, p);
            begin
                repeat (3 * p) @(posedge ref_clk);
                rc(8'hC5, {13'h0, act, 2'h0});
                wr(8'hC4, 8'hA0);
            end
        join
        @(negedge ref_clk);
        chk({14'h0, clkDivSel}, act ? 16'h0001 : 16'h0002);
        rc(8'hC0, {8'h00, ctl});
        rc(8'hC1, {8'h00, bv});
    endtask
    task automatic txf(input logic [7:0] ctl, input logic [7:0] pc, input int p, input logic [15:0] exp);
        wr(8'hBD, pc);
        wr(8'hC0, ctl);
        wr(8'hC1, 8'hA5);
        fork
            u_node.listen(p);
            begin
                repeat (2 * p) @(posedge ref_clk);
                rc(8'hC5, 16'h0008);
            end
        join
        chk(u_node.got, exp);
        rc(8'hC0, {8'h00, ctl | 8'h02});
        rc(8'hC5, 16'h0000);
    endtask
    task automatic t_m0(input logic [7:0] ctl, input int p);
        wr(8'hC0, ctl);
        wr(8'hC1, 8'h55);
        for (k = 0; (txd !== 1'b0 || k == 0) && k < 60; k++) @(negedge ref_clk);
        chk({15'h0, rxdOe}, 16'h0001);
        for (k = 0; txd !== 1'b1 && k < 60; k++) @(negedge ref_clk);
        for (; txd !== 1'b0 && k < 60; k++) @(negedge ref_clk);
        chk(k[15:0], p[15:0]);
        repeat (10 * p) @(posedge ref_clk);
        rc(8'hC0, {8'h00, ctl | 8'h02});
    endtask
    initial begin
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        rc(8'hC4, 16'h0040);
        wr(8'hBA, 8'h3C);
        rc(8'hBA, 16'h003C);
        wr(8'h80, 8'hFF);
        rc(8'h80, 16'h0000);
        wr(8'hB9, 8'hF0);
        wr(8'hBB, 8'hA5);
        m0(8'hA3, 1'b1);
        m0(8'h55, 1'b0);
        wr(8'hB9, 8'h00);
        m0(8'h55, 1'b1);
        txf(8'h40, 8'h00, 16, 16'h074A);
        txf(8'h88, 8'h00, 64, 16'h074A);
        txf(8'h88, 8'h80, 32, 16'h074A);
        txf(8'hC0, 8'h00, 16, 16'h054A);
        wr(8'hBD, 8'h00);
        t_m0(8'h00, 12);
        t_m0(8'h20, 4);
        wr(8'hBA, 8'hFF);
        wr(8'hBC, 8'h5A);
        wr(8'hC4, 8'hA0);
        wr(8'hC0, 8'hB0);
        rxf(9'h05A, 64, 8'hB0, 8'h00, 1'b1);
        rxf(9'h15A, 64, 8'hB5, 8'h5A, 1'b1);
        wr(8'hC0, 8'hB0);
        rxf(9'h133, 64, 8'hB0, 8'h5A, 1'b1);
        wr(8'hBA, 8'h00);
        rxf(9'h133, 64, 8'hB5, 8'h33, 1'b1);
        wr(8'hC0, 8'h90);
        rxf(9'h077, 64, 8'h91, 8'h77, 1'b1);
        wr(8'hC0, 8'h80);
        rxf(9'h012, 64, 8'h80, 8'h77, 1'b0);
        wr(8'hC0, 8'h70);
        wr(8'hBD, 8'h40);
        rxf(9'h0C3, 16, 8'hF0, 8'h77, 1'b1);
        wr(8'hC0, 8'h50);
        wr(8'hBD, 8'h00);
        rxf(9'h1C3, 16, 8'h55, 8'hC3, 1'b1);
        wr(8'hC4, 8'hA0);
        p0TxStart <= 1'b1;
        p0RxStart <= 1'b1;
        @(posedge ref_clk);
        p0TxStart <= 1'b0;
        p0RxStart <= 1'b0;
        wr(8'hC4, 8'hA0);
        @(negedge ref_clk);
        chk({14'h0, clkDivSel}, 16'h0001);
        rc(8'hC5, 16'h0003);
        p0TiSet <= 1'b1;
        @(posedge ref_clk);
        p0TiSet <= 1'b0;
        p0RiSet <= 1'b1;
        @(posedge ref_clk);
        p0RiSet <= 1'b0;
        rc(8'hC5, 16'h0000);
        close_out();
    end
    initial begin
        repeat (90000) @(posedge ref_clk);
        failures++;
        close_out();
    end
endmodule // spa_serial_port_bench
`default_nettype wire

/* File: verification/spa_serial_port_chk.sv */
/* Checker for spa_serial_port: bus timing, address match, clock divide.
   Assumes it is bound to the top module and sees its ports only. */
`timescale 1ns/1ns
`default_nettype none
module spa_serial_port_chk (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire logic rxdOe,
    input wire logic p0RxStart,
    input wire logic [7:0] p0RxAddr,
    input wire logic p0AddrMatch,
    input wire logic [1:0] clkDivSel
);
    // ====================
    // Shadow of written registers
    logic dpWr_q;
    logic [7:0] dpIdx_q, msk_q, slv_q, ctl_q, pm_q;
    wire logic wrPm = dpWr_q && dpIdx_q == 8'hC4;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            dpWr_q <= 1'b0;
            dpIdx_q <= 8'h00;
            msk_q <= 8'h00;
            slv_q <= 8'h00;
            ctl_q <= 8'h00;
            pm_q <= 8'h40;
        end else begin
            if (hready) begin
                dpWr_q <= hsel && htrans[1] && hwrite && haddr[31:10] == 22'h0;
                dpIdx_q <= haddr[9:2];
            end
            if (dpWr_q && hready) begin
                case (dpIdx_q)
                    8'hB9: msk_q <= hwdata[7:0];
                    8'hBB: slv_q <= hwdata[7:0];
                    8'hC0: ctl_q <= hwdata[7:0];
                    8'hC4: pm_q <= hwdata[7:0];
                    default: ;
                endcase
            end
        end
    end
    // ====================
    // Properties
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    AST_MASK_CMP: assert property (p0AddrMatch == (((p0RxAddr ^ slv_q) & msk_q) == 8'h00))
        else $error("mask compare");
    AST_MASK_ZERO: assert property (msk_q == 8'h00 |-> p0AddrMatch)
        else $error("zero mask");
    AST_OE_MODE0: assert property (rxdOe |-> ctl_q[7:6] == 2'b00)
        else $error("oe outside mode 0");
    AST_SWB_FORCE: assert property (p0RxStart && pm_q[5] |-> ##[1:2] clkDivSel == 2'h1)
        else $error("no forced divide");
    AST_CD_WRITE: assert property ($changed(clkDivSel) && clkDivSel != 2'h1 |-> $past(wrPm))
        else $error("divide moved");
    AST_RD_WAIT: assert property (hsel && htrans[1] && !hwrite && hready |=> !hreadyout ##1 hreadyout)
        else $error("read wait");
    AST_WR_NOWAIT: assert property (hsel && htrans[1] && hwrite && hready |=> hreadyout)
        else $error("write wait");
    AST_RD_UPPER: assert property (hreadyout |-> hrdata[31:8] == 24'h0 && !hresp)
        else $error("read upper");
    COV_MATCH: cover property (p0AddrMatch && msk_q != 8'h00);
    COV_MODE0: cover property (rxdOe);
    COV_FORCE: cover property (pm_q[5] && $changed(clkDivSel));
endmodule // spa_serial_port_chk
bind spa_serial_port spa_serial_port_chk u_chk (.ref_clk(ref_clk), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .rxdOe(rxdOe), .p0RxStart(p0RxStart), .p0RxAddr(p0RxAddr),
    .p0AddrMatch(p0AddrMatch), .clkDivSel(clkDivSel));
`default_nettype wire

/* File: verilog/spa_clk_div.v */
/*
 * Clock-divide selection with switchback.
 * Assumes write strobe and data come from the register slave in the
 * same clock domain.
 */
`timescale 1ns/1ns
`default_nettype none
`include "spa_serial_map.vh"

module spa_clk_div (
    input wire ref_clk,
    input wire resetn,
    input wire wrEn,
    input wire [7:0] wrData,
    input wire anyActivity,
    input wire rxStart,
    output wire [1:0] clkDivSel,
    output wire switchbackEn
);
    reg [1:0] cdQ;
    reg swbQ;
    wire [1:0] newCd;
    wire cdBlocked;
    wire viaDiv4;

    assign newCd = {wrData[`SPA_PM_CD_HI], wrData[`SPA_PM_CD_LO]};
    assign cdBlocked = swbQ & anyActivity;
    // Slow-to-slow changes must pass through divide by four first
    assign viaDiv4 = (cdQ == `SPA_CD_DIV4) | (newCd == `SPA_CD_DIV4);
    assign clkDivSel = cdQ;
    assign switchbackEn = swbQ;

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cdQ <= `SPA_CD_DIV4;
            swbQ <= 1'b0;
        end else begin
            if (wrEn) begin
                swbQ <= wrData[`SPA_PM_SWB];
            end
            if (swbQ & rxStart) begin
                cdQ <= `SPA_CD_DIV4;
            end else if (wrEn & ~cdBlocked & viaDiv4) begin
                cdQ <= newCd;
            end
        end
    end
endmodule // spa_clk_div

`default_nettype wire

/* File: verilog/spa_serial_map.vh */
/*
 * Register indices, field positions, reset values and divider counts
 * for the second serial port with address recognition.
 * Assumes byte address = 4 * index on a 32-bit bus.
 */
`ifndef SPA_SERIAL_MAP_VH
`define SPA_SERIAL_MAP_VH

// ==========================================
// Register indices
`define SPA_IDX_MASK_P0 8'hB9
`define SPA_IDX_MASK_P1 8'hBA
`define SPA_IDX_SLAVE_ADDR_P0_P0 8'hBB
`define SPA_IDX_SLAVE_ADDR_P0_P1 8'hBC
`define SPA_IDX_PWR_CTRL 8'hBD
`define SPA_IDX_BAUD_P1 8'hBE
`define SPA_IDX_CTRL_P1 8'hC0
`define SPA_IDX_BUF_P1 8'hC1
`define SPA_IDX_PWR_MGMT 8'hC4
`define SPA_IDX_STATUS 8'hC5

// ==========================================
// Serial control fields
`define SPA_CTL_MODE_HI 7
`define SPA_CTL_MODE_LO 6
`define SPA_CTL_MP_EN 5
`define SPA_CTL_RX_EN 4
`define SPA_CTL_TX_NINTH 3
`define SPA_CTL_RX_NINTH 2
`define SPA_CTL_TX_INT 1
`define SPA_CTL_RX_INT 0

// ==========================================
// Power control, clock divide and status fields
`define SPA_PC_DOUBLE 7
`define SPA_PC_FE_SEL 6
`define SPA_PM_CD_HI 7
`define SPA_PM_CD_LO 6
`define SPA_PM_SWB 5
`define SPA_ST_TXA1 3
`define SPA_ST_RXA1 2
`define SPA_ST_TXA0 1
`define SPA_ST_RXA0 0

// ==========================================
// Reset values
`define SPA_RST_REG8 8'h00
`define SPA_CD_DIV4 2'h1

// ==========================================
// Bit periods in reference clocks, frame lengths
`define SPA_M0_DIV_SLOW 13'h00C
`define SPA_M0_DIV_FAST 13'h004
`define SPA_M2_DIV_SLOW 13'h040
`define SPA_M2_DIV_FAST 13'h020
`define SPA_OVERSAMPLE_SH 4
`define SPA_BITS_M0 4'h8
`define SPA_BITS_M1 4'hA
`define SPA_BITS_M23 4'hB

`endif

/* File: verilog/spa_serial_port.v */
/*
 * Second serial port with automatic address recognition, activity
 * status and switchback, behind an AHB-Lite register slave.
 * Assumes the first serial port lives outside and reports its own
 * start and flag-set pulses; all inputs synchronous to ref_clk.
 */
// Local design decision: the AHB-Lite interface to the registers.
// Function
// - Compare address bits only where mask is one
// - All-zero mask accepts any address
// - Two mode bits pick three frame formats
// - Select bit turns bit 7 into framing error
// - Modes 2/3 multiproc: no RI when ninth zero
// - Mode 1 multiproc: RI only on valid stop
// - Mode 0: multiproc bit picks divide 12 or 4
// - Receive only while receive enable is one
// - Modes 2/3 send transmit ninth bit
// - Received ninth bit: ninth, stop, or unused
// - TI at eighth bit end or stop start
// - RI at eighth bit end or mid stop
// - Buffer: reads receive, writes transmit
// - Transmit activity until TI set by hardware
// - Receive activity until RI set by hardware (also dropped at a rejected or false frame)
// - Activity with switchback blocks divide changes
// - Reception with switchback forces divide by four
// - First port activity bits cleared by its flags
`timescale 1ns/1ns
`default_nettype none
`include "spa_serial_map.vh"

module spa_serial_port (
    input wire ref_clk,
    input wire resetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire [31:0] hrdata,
    output wire hresp,
    output wire txd,
    input wire rxdIn,
    output wire rxdOut,
    output wire rxdOe,
    input wire p0TxStart,
    input wire p0RxStart,
    input wire p0TiSet,
    input wire p0RiSet,
    input wire [7:0] p0RxAddr,
    output wire p0AddrMatch,
    output wire [1:0] clkDivSel
);
    // ==========================================
    // Shared decode
    function addrMatch;
        input [7:0] rxAddr;
        input [7:0] slave;
        input [7:0] mask;
        begin
            addrMatch = ~|((rxAddr ^ slave) & mask);
        end
    endfunction

    function [12:0] bitPeriod;
        input [1:0] mode;
        input mpEn;
        input dbl;
        input [7:0] div;
        begin
            case (mode)
                2'h0: bitPeriod = mpEn ? `SPA_M0_DIV_FAST : `SPA_M0_DIV_SLOW;
                2'h2: bitPeriod = dbl ? `SPA_M2_DIV_FAST : `SPA_M2_DIV_SLOW;
                default: bitPeriod = {({1'b0, div} + 9'h001), 4'h0};
            endcase
        end
    endfunction

    // ==========================================
    // AHB-Lite slave
    reg dphValidQ, dphWriteQ, dphMappedQ, rdDoneQ;
    reg [7:0] dphIdxQ;
    reg [7:0] rdDataQ;
    wire dphRead = dphValidQ & ~dphWriteQ;
    wire wrEn = dphValidQ & dphWriteQ & dphMappedQ;
    wire [7:0] wd = hwdata[7:0];

    // Reads take one wait state so a write just before is visible
    assign hreadyout = ~(dphRead & ~rdDoneQ);
    assign hrdata = {24'h00_0000, rdDataQ};
    assign hresp = 1'b0;

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            dphValidQ <= 1'b0;
            dphWriteQ <= 1'b0;
            dphMappedQ <= 1'b0;
            dphIdxQ <= `SPA_RST_REG8;
            rdDoneQ <= 1'b0;
        end else begin
            rdDoneQ <= dphRead & ~rdDoneQ;
            if (hready) begin
                dphValidQ <= hsel & htrans[1];
                dphWriteQ <= hwrite;
                dphMappedQ <= ~|haddr[31:10];
                dphIdxQ <= haddr[9:2];
            end
        end
    end

    // ==========================================
    // Registers
    reg [7:0] maskP0Q, maskP1Q, saddrP0Q, saddrP1Q, baudQ, rxBufQ, pmrRdQ;
    reg modeHiQ, modeLoQ, mpEnQ, renQ, tb8Q, rb8Q, tiQ, riQ, feQ;
    reg dblQ, feSelQ;
    reg txa1Q, rxa1Q, txa0Q, rxa0Q;
    wire [1:0] mode = {modeHiQ, modeLoQ};
    wire ctrlWr = wrEn & (dphIdxQ == `SPA_IDX_CTRL_P1);
    wire bufWr = wrEn & (dphIdxQ == `SPA_IDX_BUF_P1);
    wire pmrWr = wrEn & (dphIdxQ == `SPA_IDX_PWR_MGMT);
    wire [12:0] period = bitPeriod(mode, mpEnQ, dblQ, baudQ);
    wire [12:0] halfPeriod = {1'b0, period[12:1]};
    wire swbEn;
    wire [7:0] ctrlRd = {feSelQ ? feQ : modeHiQ, modeLoQ, mpEnQ, renQ, tb8Q, rb8Q, tiQ, riQ};
    wire [7:0] statusRd = {4'h0, txa1Q, rxa1Q, txa0Q, rxa0Q};

    assign p0AddrMatch = addrMatch(p0RxAddr, saddrP0Q, maskP0Q);

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rdDataQ <= `SPA_RST_REG8;
        end else if (dphRead & ~rdDoneQ) begin
            rdDataQ <= `SPA_RST_REG8;
            if (dphMappedQ) begin
                case (dphIdxQ)
                    `SPA_IDX_MASK_P0: rdDataQ <= maskP0Q;
                    `SPA_IDX_MASK_P1: rdDataQ <= maskP1Q;
                    `SPA_IDX_SLAVE_ADDR_P0_P0: rdDataQ <= saddrP0Q;
                    `SPA_IDX_SLAVE_ADDR_P0_P1: rdDataQ <= saddrP1Q;
                    `SPA_IDX_PWR_CTRL: rdDataQ <= {dblQ, feSelQ, 6'h00};
                    `SPA_IDX_BAUD_P1: rdDataQ <= baudQ;
                    `SPA_IDX_CTRL_P1: rdDataQ <= ctrlRd;
                    `SPA_IDX_BUF_P1: rdDataQ <= rxBufQ;
                    `SPA_IDX_PWR_MGMT: rdDataQ <= pmrRdQ;
                    `SPA_IDX_STATUS: rdDataQ <= statusRd;
                    default: rdDataQ <= `SPA_RST_REG8;
                endcase
            end
        end
    end

    // ==========================================
    // Transmit engine
    localparam TX_IDLE = 2'b01;
    localparam TX_SHIFT = 2'b10;
    reg [1:0] txStateQ;
    reg [10:0] txShiftQ;
    reg [3:0] txLeftQ;
    reg [12:0] txTimerQ;
    reg txIntSet;
    wire txBitEnd = (txStateQ == TX_SHIFT) & (txTimerQ == 13'h0000);

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            txStateQ <= TX_IDLE;
            txShiftQ <= 11'h7FF;
            txLeftQ <= 4'h0;
            txTimerQ <= 13'h0000;
        end else begin
            case (txStateQ)
                TX_IDLE: begin
                    if (bufWr) begin
                        txStateQ <= TX_SHIFT;
                        txTimerQ <= period - 13'h0001;
                        if (mode == 2'h0) begin
                            txShiftQ <= {3'h7, wd};
                            txLeftQ <= `SPA_BITS_M0;
                        end else if (mode == 2'h1) begin
                            txShiftQ <= {2'h3, wd, 1'b0};
                            txLeftQ <= `SPA_BITS_M1;
                        end else begin
                            txShiftQ <= {1'b1, tb8Q, wd, 1'b0};
                            txLeftQ <= `SPA_BITS_M23;
                        end
                    end
                end
                TX_SHIFT: begin
                    if (txBitEnd) begin
                        txShiftQ <= {1'b1, txShiftQ[10:1]};
                        txLeftQ <= txLeftQ - 4'h1;
                        txTimerQ <= period - 13'h0001;
                        if (txLeftQ == 4'h1) begin
                            txStateQ <= TX_IDLE;
                        end
                    end else begin
                        txTimerQ <= txTimerQ - 13'h0001;
                    end
                end
                default: txStateQ <= TX_IDLE;
            endcase
        end
    end

    // Mode 0 sets TI when the eighth bit ends, others as stop starts
    always @* begin
        txIntSet = 1'b0;
        if (txBitEnd) begin
            txIntSet = (mode == 2'h0) ? (txLeftQ == 4'h1) : (txLeftQ == 4'h2);
        end
    end

    // ==========================================
    // Receive engine
    localparam RX_IDLE = 2'b01;
    localparam RX_SHIFT = 2'b10;
    reg [1:0] rxStateQ;
    reg [10:0] rxShiftQ;
    reg [3:0] rxLeftQ, rxTotalQ;
    reg [12:0] rxTimerQ;
    reg rxPrevQ;
    reg rxIntSet, feSet, rxLoad, rxDone;
    reg [7:0] rxData;
    reg rxNinth;
    wire rxStartAsync = (rxStateQ == RX_IDLE) & renQ & (mode != 2'h0) & rxPrevQ & ~rxdIn;
    wire rxStartSync = (rxStateQ == RX_IDLE) & renQ & (mode == 2'h0) & ~riQ & ~txa1Q;
    wire rxSample = (rxStateQ == RX_SHIFT) & (rxTimerQ == 13'h0000);
    wire [10:0] rxNext = {rxdIn, rxShiftQ[10:1]};
    wire rxFalseStart = rxSample & (mode != 2'h0) & (rxLeftQ == rxTotalQ) & rxdIn;
    wire rxLast = rxSample & (rxLeftQ == 4'h1);

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rxStateQ <= RX_IDLE;
            rxShiftQ <= 11'h000;
            rxLeftQ <= 4'h0;
            rxTotalQ <= 4'h0;
            rxTimerQ <= 13'h0000;
            rxPrevQ <= 1'b1;
        end else begin
            rxPrevQ <= rxdIn;
            case (rxStateQ)
                RX_IDLE: begin
                    if (rxStartAsync | rxStartSync) begin
                        rxStateQ <= RX_SHIFT;
                        rxShiftQ <= 11'h000;
                        // Async samples mid-bit, sync at each bit end
                        rxTimerQ <= rxStartSync ? period - 13'h0001 : halfPeriod - 13'h0001;
                        if (mode == 2'h0) begin
                            rxLeftQ <= `SPA_BITS_M0;
                            rxTotalQ <= `SPA_BITS_M0;
                        end else if (mode == 2'h1) begin
                            rxLeftQ <= `SPA_BITS_M1;
                            rxTotalQ <= `SPA_BITS_M1;
                        end else begin
                            rxLeftQ <= `SPA_BITS_M23;
                            rxTotalQ <= `SPA_BITS_M23;
                        end
                    end
                end
                RX_SHIFT: begin
                    if (rxSample) begin
                        rxShiftQ <= rxNext;
                        rxLeftQ <= rxLeftQ - 4'h1;
                        rxTimerQ <= period - 13'h0001;
                        if (rxFalseStart | rxLast) begin
                            rxStateQ <= RX_IDLE;
                        end
                    end else begin
                        rxTimerQ <= rxTimerQ - 13'h0001;
                    end
                end
                default: rxStateQ <= RX_IDLE;
            endcase
        end
    end

    // Frame completion and acceptance
    always @* begin
        rxIntSet = 1'b0;
        feSet = 1'b0;
        rxLoad = 1'b0;
        rxDone = rxFalseStart;
        rxData = rxNext[10:3];
        rxNinth = 1'b0;
        if (rxLast) begin
            rxDone = 1'b1;
            case (mode)
                2'h0: begin
                    rxLoad = 1'b1;
                    rxIntSet = 1'b1;
                end
                2'h1: begin
                    rxData = rxNext[9:2];
                    rxNinth = rxNext[10];
                    feSet = ~rxNext[10];
                    rxLoad = ~mpEnQ | rxNext[10];
                    rxIntSet = rxLoad;
                end
                default: begin
                    rxData = rxNext[8:1];
                    rxNinth = rxNext[9];
                    feSet = ~rxNext[10];
                    // Multiproc frames with ninth set are addresses
                    rxLoad = ~mpEnQ | (rxNinth & addrMatch(rxData, saddrP1Q, maskP1Q));
                    rxIntSet = rxLoad;
                end
            endcase
        end
    end

    // ==========================================
    // Register updates; hardware sets win over software clears
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            maskP0Q <= `SPA_RST_REG8;
            maskP1Q <= `SPA_RST_REG8;
            saddrP0Q <= `SPA_RST_REG8;
            saddrP1Q <= `SPA_RST_REG8;
            baudQ <= `SPA_RST_REG8;
            rxBufQ <= `SPA_RST_REG8;
            pmrRdQ <= `SPA_RST_REG8;
            {modeHiQ, modeLoQ, mpEnQ, renQ, tb8Q, rb8Q, tiQ, riQ} <= `SPA_RST_REG8;
            feQ <= 1'b0;
            dblQ <= 1'b0;
            feSelQ <= 1'b0;
        end else begin
            if (wrEn) begin
                case (dphIdxQ)
                    `SPA_IDX_MASK_P0: maskP0Q <= wd;
                    `SPA_IDX_MASK_P1: maskP1Q <= wd;
                    `SPA_IDX_SLAVE_ADDR_P0_P0: saddrP0Q <= wd;
                    `SPA_IDX_SLAVE_ADDR_P0_P1: saddrP1Q <= wd;
                    `SPA_IDX_BAUD_P1: baudQ <= wd;
                    `SPA_IDX_PWR_CTRL: begin
                        dblQ <= wd[`SPA_PC_DOUBLE];
                        feSelQ <= wd[`SPA_PC_FE_SEL];
                    end
                    default: begin
                    end
                endcase
            end
            pmrRdQ <= {clkDivSel, swbEn, 5'h00};
            if (ctrlWr) begin
                if (!feSelQ) begin
                    modeHiQ <= wd[`SPA_CTL_MODE_HI];
                end
                modeLoQ <= wd[`SPA_CTL_MODE_LO];
                mpEnQ <= wd[`SPA_CTL_MP_EN];
                renQ <= wd[`SPA_CTL_RX_EN];
                tb8Q <= wd[`SPA_CTL_TX_NINTH];
            end
            if (rxLoad & (mode != 2'h0)) begin
                rb8Q <= rxNinth;
            end else if (ctrlWr) begin
                rb8Q <= wd[`SPA_CTL_RX_NINTH];
            end
            tiQ <= txIntSet | (ctrlWr ? wd[`SPA_CTL_TX_INT] : tiQ);
            riQ <= rxIntSet | (ctrlWr ? wd[`SPA_CTL_RX_INT] : riQ);
            feQ <= feSet | ((ctrlWr & feSelQ) ? wd[`SPA_CTL_MODE_HI] : feQ);
            if (rxLoad) begin
                rxBufQ <= rxData;
            end
        end
    end

    // ==========================================
    // Activity status and clock divide
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            {txa1Q, rxa1Q, txa0Q, rxa0Q} <= 4'h0;
        end else begin
            txa1Q <= ~txIntSet & (txa1Q | (bufWr & (txStateQ == TX_IDLE)));
            // Also dropped on a rejected or false frame so it cannot stick
            rxa1Q <= ~(rxIntSet | rxDone) & (rxa1Q | rxStartAsync | rxStartSync);
            txa0Q <= ~p0TiSet & (txa0Q | p0TxStart);
            rxa0Q <= ~p0RiSet & (rxa0Q | p0RxStart);
        end
    end

    spa_clk_div uClkDiv (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .wrEn(pmrWr),
        .wrData(wd),
        .anyActivity(txa1Q | rxa1Q | txa0Q | rxa0Q),
        .rxStart(rxStartAsync | rxStartSync | p0RxStart),
        .clkDivSel(clkDivSel),
        .switchbackEn(swbEn)
    );

    // ==========================================
    // Pins: mode 0 puts data on rxd and shift clock on txd
    wire m0 = (mode == 2'h0);
    wire txClkLow = (txStateQ == TX_SHIFT) & (txTimerQ >= halfPeriod);
    wire rxClkLow = (rxStateQ == RX_SHIFT) & (rxTimerQ >= halfPeriod);
    assign txd = m0 ? ~(txClkLow | rxClkLow) : ((txStateQ == TX_SHIFT) ? txShiftQ[0] : 1'b1);
    assign rxdOut = txShiftQ[0];
    assign rxdOe = m0 & (txStateQ == TX_SHIFT);
endmodule // spa_serial_port

`default_nettype wire
